// file: include/spf_regs.svh
/*
 * Constants for the serial port with soft flow control: timing, codes, reset values.
 * Assumes a 25 MHz system clock; included by the design file.
 */
`ifndef SPF_REGS_SVH
`define SPF_REGS_SVH

// ==========================================================================
// Timing
// ==========================================================================
`define SPF_CLK_HZ        25000000
`define SPF_BAUD_57600    57600
`define SPF_BAUD_38400    38400
`define SPF_BAUD_19200    19200
`define SPF_BAUD_9600     9600
`define SPF_BAUD_4800     4800
`define SPF_BAUD_2400     2400
`define SPF_BAUD_1200     1200
`define SPF_BAUD_600      600
`define SPF_BAUD_300      300
`define SPF_OVERSAMPLE    16

// ==========================================================================
// Character codes
// ==========================================================================
`define SPF_CODE_XON      8'h11
`define SPF_CODE_XOFF     8'h13
`define SPF_CODE_CTRL_C   8'h03
`define SPF_CODE_CTRL_X   8'h18
`define SPF_CODE_CR       8'h0d
`define SPF_CODE_LF       8'h0a

// ==========================================================================
// Reset values
// ==========================================================================
`define SPF_RST_LINE      1'b1
`define SPF_RST_COUNT     16'h0000

`endif

// file: include/spf_pkg.sv
/*
 * Types shared by the serial port with soft flow control.
 * Assumes spf_regs.svh is on the include path.
 */
package spf_pkg;

    typedef enum logic [1:0] {
        SPF_PAR_NONE = 2'h0,
        SPF_PAR_EVEN = 2'h1,
        SPF_PAR_ODD  = 2'h2
    } spf_parity_e;

    typedef enum logic [1:0] {
        SPF_TERM_LF   = 2'h0,
        SPF_TERM_CR   = 2'h1,
        SPF_TERM_LFCR = 2'h2,
        SPF_TERM_CRLF = 2'h3
    } spf_term_e;

    // Gray-coded frame states along start, data, parity, stop.
    typedef enum logic [2:0] {
        SPF_FR_IDLE   = 3'h0,
        SPF_FR_START  = 3'h1,
        SPF_FR_DATA   = 3'h3,
        SPF_FR_PARITY = 3'h2,
        SPF_FR_STOP   = 3'h6
    } spf_frame_e;

    typedef struct packed {
        logic [3:0]  baud_sel;
        logic        eight_bits;
        spf_parity_e parity;
        spf_term_e   term;
        logic        soft_flow_select;
    } spf_cfg_s;

    typedef struct packed {
        spf_frame_e  st;
        logic [3:0]  tick;
        logic [3:0]  bit_idx;
        logic [8:0]  shreg;
        logic        par;
    } spf_frame_s;

endpackage : spf_pkg

// file: src/spf_serial_port.sv
/*
 * Serial port with soft flow control: transmitter, receiver, input line buffer,
 * X_ON/X_OFF flow control, message terminators and break characters.
 * Assumes a 25 MHz clock, a synchronous active-high reset and a host that
 * reads released command lines and feeds response bytes with end-of-message marks.
 */
// How it works
// [RULE_01] Seven or eight data bits, one stop.
// [RULE_02] Parity none, even or odd, generated, checked.
// [RULE_03] Nine selectable baud rates, 57.6k to 300.
// [RULE_04] Host must match rate, bits and parity.
// [RULE_05] Control-C or control-X aborts and discards output.
// [RULE_06] Each message ends with selected terminator.
// [RULE_07] No hardware flow control lines used.
// [RULE_08] Soft flow only when selected.
// [RULE_09] Send X_OFF above three quarters full.
// [RULE_10] Send X_ON below half full.
// [RULE_11] Host stops after X_OFF until X_ON.
// [RULE_12] Received X_OFF stops output until X_ON.
// [RULE_13] Command line released after carriage return.
// [RULE_14] Without flow control overflowing characters are lost.
// [RULE_15] Only transmit, receive and ground used.
// [RULE_16] Low start bit, LSB first, idle high.
// [RULE_17] X_ON 0x11, X_OFF 0x13, parity error flagged.
`timescale 1ns/100ps
`include "spf_regs.svh"

module spf_serial_port #(
    parameter int DEPTH = 64
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    input  wire spf_pkg::spf_cfg_s cfg,
    input  wire logic             rxd_pin,
    output logic                  txd_pin,
    input  wire logic             out_valid,
    input  wire logic [7:0]       out_data,
    input  wire logic             out_last,
    output logic                  out_ready,
    output logic                  line_ready,
    output logic [7:0]            line_data,
    input  wire logic             line_pop,
    output logic                  abort_pulse,
    output logic                  rx_parity_err,
    output logic                  rx_overrun,
    output logic                  tx_held
);

    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 4 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_bad
        $error("DEPTH must be a power of two of at least 4");
    end

    // ======================================================================
    // Baud divisors
    // ======================================================================
    function automatic logic [15:0] div_of(input logic [3:0] sel);
        int r;
        case (sel)
            4'h0: r = `SPF_BAUD_57600;
            4'h1: r = `SPF_BAUD_38400;
            4'h2: r = `SPF_BAUD_19200;
            4'h3: r = `SPF_BAUD_9600;
            4'h4: r = `SPF_BAUD_4800;
            4'h5: r = `SPF_BAUD_2400;
            4'h6: r = `SPF_BAUD_1200;
            4'h7: r = `SPF_BAUD_600;
            default: r = `SPF_BAUD_300;
        endcase
        div_of = 16'(`SPF_CLK_HZ / (r * `SPF_OVERSAMPLE) - 1); // RULE_03
    endfunction : div_of

    typedef struct packed {
        logic                 rx_s1;
        logic                 rx_s2;
        logic [15:0]          bdiv;
        spf_pkg::spf_frame_s  tx;
        spf_pkg::spf_frame_s  rx;
        logic [DEPTH-1:0][7:0] mem;
        logic [AW:0]          wr;
        logic [AW:0]          rd;
        logic [AW:0]          lines;
        logic                 xoff_sent;
        logic                 need_xoff;
        logic                 need_xon;
        logic                 peer_stop;
        logic [1:0]           term_left;
        logic                 txd;
        logic                 abort;
        logic                 perr;
        logic                 ovr;
        logic [7:0]           line_q;
    } state_s;

    state_s s_q;
    state_s s_d;

    logic         os_tick;
    logic [AW:0]  fill;
    logic         tx_idle;
    logic         tx_go;
    logic [7:0]   tx_byte;
    logic         take_user;
    logic [7:0]   rx_byte;
    logic [1:0]   nterm;

    assign os_tick = (s_q.bdiv == '0);
    assign fill    = AW'(0) + (s_q.wr - s_q.rd);
    assign tx_idle = (s_q.tx.st == spf_pkg::SPF_FR_IDLE);

    // ======================================================================
    // Transmit source selection
    // ======================================================================
    // Flow characters jump ahead of data and go out even while the peer holds us.
    always_comb begin
        tx_go     = 1'b0;
        tx_byte   = 8'h00;
        take_user = 1'b0;
        nterm     = (cfg.term == spf_pkg::SPF_TERM_LFCR ||
                     cfg.term == spf_pkg::SPF_TERM_CRLF) ? 2'h2 : 2'h1;
        if (tx_idle && os_tick) begin
            if (s_q.need_xoff) begin
                tx_go   = 1'b1; // RULE_09
                tx_byte = `SPF_CODE_XOFF; // RULE_17
            end else if (s_q.need_xon) begin
                tx_go   = 1'b1; // RULE_10
                tx_byte = `SPF_CODE_XON;
            end else if (!(cfg.soft_flow_select && s_q.peer_stop)) begin // RULE_12
                if (s_q.term_left != 2'h0) begin
                    tx_go = 1'b1; // RULE_06
                    case (cfg.term)
                        spf_pkg::SPF_TERM_LF:   tx_byte = `SPF_CODE_LF;
                        spf_pkg::SPF_TERM_CR:   tx_byte = `SPF_CODE_CR;
                        spf_pkg::SPF_TERM_LFCR: tx_byte = (s_q.term_left == 2'h2) ?
                                                          `SPF_CODE_LF : `SPF_CODE_CR;
                        default:                tx_byte = (s_q.term_left == 2'h2) ?
                                                          `SPF_CODE_CR : `SPF_CODE_LF;
                    endcase
                end else if (out_valid) begin
                    tx_go     = 1'b1;
                    tx_byte   = out_data;
                    take_user = 1'b1;
                end
            end
        end
    end

    assign out_ready = take_user && clk_en;

    // ======================================================================
    // Next state
    // ======================================================================
    always_comb begin
        s_d       = s_q;
        rx_byte   = s_q.rx.shreg[7:0];
        s_d.abort = 1'b0;
        s_d.rx_s1 = rxd_pin;
        s_d.rx_s2 = s_q.rx_s1;
        s_d.bdiv  = os_tick ? div_of(cfg.baud_sel) : s_q.bdiv - 16'h0001;

        // Flow thresholds follow the fill level with hysteresis.
        if (!cfg.soft_flow_select) begin
            s_d.need_xoff = 1'b0; // RULE_08
            s_d.need_xon  = 1'b0;
            s_d.xoff_sent = 1'b0;
            s_d.peer_stop = 1'b0;
        end else if (!s_q.xoff_sent && fill > (AW + 1)'(DEPTH * 3 / 4)) begin
            s_d.need_xoff = 1'b1; // RULE_09
            s_d.xoff_sent = 1'b1;
        end else if (s_q.xoff_sent && !s_q.need_xoff && fill < (AW + 1)'(DEPTH / 2)) begin
            s_d.need_xon  = 1'b1; // RULE_10
            s_d.xoff_sent = 1'b0;
        end

        // Transmitter, one bit per sixteen ticks.
        if (tx_go) begin
            s_d.tx.st    = spf_pkg::SPF_FR_START;
            s_d.tx.tick  = 4'h0;
            s_d.tx.shreg = {1'b0, tx_byte};
            s_d.tx.par   = (cfg.parity == spf_pkg::SPF_PAR_ODD);
            s_d.txd      = 1'b0; // RULE_16
            if (s_q.need_xoff && tx_byte == `SPF_CODE_XOFF) begin
                s_d.need_xoff = 1'b0;
            end else if (s_q.need_xon && !s_q.need_xoff) begin
                s_d.need_xon = 1'b0;
            end else if (s_q.term_left != 2'h0) begin
                s_d.term_left = s_q.term_left - 2'h1;
            end else if (out_last) begin
                s_d.term_left = nterm;
            end
        end else if (!tx_idle && os_tick) begin
            s_d.tx.tick = s_q.tx.tick + 4'h1;
            if (s_q.tx.tick == 4'hf) begin
                case (s_q.tx.st)
                    spf_pkg::SPF_FR_START,
                    spf_pkg::SPF_FR_DATA: begin
                        if (s_q.tx.st == spf_pkg::SPF_FR_DATA &&
                            s_q.tx.bit_idx == (cfg.eight_bits ? 4'h7 : 4'h6)) begin // RULE_01
                            s_d.tx.st = (cfg.parity == spf_pkg::SPF_PAR_NONE) ?
                                        spf_pkg::SPF_FR_STOP : spf_pkg::SPF_FR_PARITY;
                            s_d.txd   = (cfg.parity == spf_pkg::SPF_PAR_NONE) ?
                                        1'b1 : s_q.tx.par; // RULE_02
                        end else begin
                            s_d.tx.bit_idx = (s_q.tx.st == spf_pkg::SPF_FR_START) ?
                                             4'h0 : s_q.tx.bit_idx + 4'h1;
                            s_d.tx.st      = spf_pkg::SPF_FR_DATA;
                            s_d.txd        = s_q.tx.shreg[0]; // RULE_16
                            s_d.tx.par     = s_q.tx.par ^ s_q.tx.shreg[0];
                            s_d.tx.shreg   = {1'b0, s_q.tx.shreg[8:1]};
                        end
                    end
                    spf_pkg::SPF_FR_PARITY: begin
                        s_d.tx.st = spf_pkg::SPF_FR_STOP;
                        s_d.txd   = 1'b1;
                    end
                    default: begin
                        s_d.tx.st = spf_pkg::SPF_FR_IDLE; // RULE_01
                        s_d.txd   = 1'b1;
                    end
                endcase
            end
        end

        // Receiver samples mid-bit on the synchronised line only.
        if (os_tick) begin
            s_d.rx.tick = s_q.rx.tick + 4'h1;
            case (s_q.rx.st)
                spf_pkg::SPF_FR_IDLE: begin
                    s_d.rx.tick = 4'h0;
                    if (!s_q.rx_s2) begin
                        s_d.rx.st = spf_pkg::SPF_FR_START; // RULE_16
                    end
                end
                spf_pkg::SPF_FR_START: begin
                    if (s_q.rx.tick == 4'h7) begin
                        s_d.rx.tick    = 4'h0;
                        s_d.rx.bit_idx = 4'h0;
                        s_d.rx.shreg   = '0;
                        s_d.rx.par     = (cfg.parity == spf_pkg::SPF_PAR_ODD);
                        s_d.rx.st      = s_q.rx_s2 ? spf_pkg::SPF_FR_IDLE :
                                         spf_pkg::SPF_FR_DATA;
                    end
                end
                spf_pkg::SPF_FR_DATA: begin
                    if (s_q.rx.tick == 4'hf) begin
                        s_d.rx.par   = s_q.rx.par ^ s_q.rx_s2;
                        s_d.rx.shreg = cfg.eight_bits ?
                                       {1'b0, s_q.rx_s2, s_q.rx.shreg[7:1]} :
                                       {2'b00, s_q.rx_s2, s_q.rx.shreg[6:1]}; // RULE_01
                        s_d.rx.bit_idx = s_q.rx.bit_idx + 4'h1;
                        if (s_q.rx.bit_idx == (cfg.eight_bits ? 4'h7 : 4'h6)) begin
                            s_d.rx.st = (cfg.parity == spf_pkg::SPF_PAR_NONE) ?
                                        spf_pkg::SPF_FR_STOP : spf_pkg::SPF_FR_PARITY;
                        end
                    end
                end
                spf_pkg::SPF_FR_PARITY: begin
                    if (s_q.rx.tick == 4'hf) begin
                        s_d.rx.par = s_q.rx.par ^ s_q.rx_s2; // RULE_02
                        s_d.rx.st  = spf_pkg::SPF_FR_STOP;
                    end
                end
                default: begin
                    if (s_q.rx.tick == 4'hf) begin
                        s_d.rx.st = spf_pkg::SPF_FR_IDLE;
                        if (cfg.parity != spf_pkg::SPF_PAR_NONE && s_q.rx.par) begin
                            s_d.perr = 1'b1; // RULE_17
                        end
                        if (rx_byte == `SPF_CODE_CTRL_C || rx_byte == `SPF_CODE_CTRL_X) begin
                            s_d.abort     = 1'b1; // RULE_05
                            s_d.term_left = 2'h0;
                            s_d.wr        = s_q.rd;
                            s_d.lines     = '0;
                        end else if (cfg.soft_flow_select && rx_byte == `SPF_CODE_XOFF) begin
                            s_d.peer_stop = 1'b1; // RULE_12
                        end else if (cfg.soft_flow_select && rx_byte == `SPF_CODE_XON) begin
                            s_d.peer_stop = 1'b0;
                        end else if (fill == (AW + 1)'(DEPTH)) begin
                            s_d.ovr = 1'b1; // RULE_14
                        end else begin
                            s_d.mem[s_q.wr[AW-1:0]] = rx_byte; // RULE_13
                            s_d.wr = s_q.wr + (AW + 1)'(1);
                            if (rx_byte == `SPF_CODE_CR) begin
                                s_d.lines = s_q.lines + (AW + 1)'(1); // RULE_13
                            end
                        end
                    end
                end
            endcase
        end

        // Host pops released line bytes; a popped CR closes one line.
        if (line_pop && s_q.lines != '0 && s_d.wr != s_q.rd) begin
            s_d.rd     = s_q.rd + (AW + 1)'(1);
            // Read the updated store so a byte landing this cycle is not shown stale.
            s_d.line_q = s_d.mem[(s_q.rd + (AW + 1)'(1)) & (AW + 1)'(DEPTH - 1)];
            if (s_q.mem[s_q.rd[AW-1:0]] == `SPF_CODE_CR) begin
                s_d.lines = s_d.lines - (AW + 1)'(1);
            end
        end else begin
            s_d.line_q = s_d.mem[s_q.rd[AW-1:0]];
        end
    end

    // ======================================================================
    // State register
    // ======================================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q       <= '0;
            s_q.rx_s1 <= `SPF_RST_LINE;
            s_q.rx_s2 <= `SPF_RST_LINE;
            s_q.txd   <= `SPF_RST_LINE;
            s_q.bdiv  <= `SPF_RST_COUNT;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // Only TXD and RXD are used; no modem control port exists. RULE_07 RULE_15
    assign txd_pin       = s_q.txd; // RULE_15
    assign line_ready    = (s_q.lines != '0);
    assign line_data     = s_q.line_q;
    assign abort_pulse   = s_q.abort;
    assign rx_parity_err = s_q.perr;
    assign rx_overrun    = s_q.ovr;
    assign tx_held       = cfg.soft_flow_select && s_q.peer_stop;

endmodule : spf_serial_port

// file: bench/spf_serial_port_chk.sv
/* Port checker for spf_serial_port.
   Assumes it is bound to every spf_serial_port instance; sees only its ports. */
`timescale 1ns/100ps
module spf_serial_port_chk #(
    parameter int DEPTH = 64
) (
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              clk_en,
    input wire spf_pkg::spf_cfg_s cfg,
    input wire logic              rxd_pin,
    input wire logic              txd_pin,
    input wire logic              out_valid,
    input wire logic [7:0]        out_data,
    input wire logic              out_last,
    input wire logic              out_ready,
    input wire logic              line_ready,
    input wire logic [7:0]        line_data,
    input wire logic              line_pop,
    input wire logic              abort_pulse,
    input wire logic              rx_parity_err,
    input wire logic              rx_overrun,
    input wire logic              tx_held
);
    // ==========================================================================
    // Sequences
    // ==========================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_take;
        out_valid && out_ready;
    endsequence
    sequence s_start_low;
        !txd_pin [*8];
    endsequence
    // ==========================================================================
    // Assertions
    // ==========================================================================
    // Reset is checked while it is applied, so this one is never disabled.
    AST_RESET_IDLE: assert property (disable iff (1'b0) rst |=> txd_pin && !line_ready
        && !abort_pulse && !rx_parity_err && !rx_overrun) else $error("bad reset state");
    AST_START_LOW: assert property (s_take |=> s_start_low)
        else $error("start bit missing");
    AST_ONE_TAKE: assert property (s_take |=> !out_ready)
        else $error("second byte taken inside a frame");
    AST_HELD_BLOCKS: assert property (tx_held |-> !out_ready)
        else $error("byte taken while held");
    AST_ABORT_PULSE: assert property (abort_pulse |=> !abort_pulse)
        else $error("abort pulse too long");
    AST_PERR_STICKY: assert property (rx_parity_err |=> rx_parity_err)
        else $error("parity error flag dropped");
    AST_OVR_STICKY: assert property (rx_overrun |=> rx_overrun)
        else $error("overrun flag dropped");
    AST_LINE_HOLD: assert property (line_ready && !line_pop |=> !line_ready || $stable(line_data))
        else $error("line byte changed without pop");
endmodule : spf_serial_port_chk

bind spf_serial_port spf_serial_port_chk #(.DEPTH(DEPTH)) u_chk (.clk(clk), .rst(rst),
    .clk_en(clk_en), .cfg(cfg), .rxd_pin(rxd_pin), .txd_pin(txd_pin), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_ready(out_ready), .line_ready(line_ready),
    .line_data(line_data), .line_pop(line_pop), .abort_pulse(abort_pulse),
    .rx_parity_err(rx_parity_err), .rx_overrun(rx_overrun), .tx_held(tx_held));

// file: bench/spf_host_model.sv
/* Behavioural host controller on the far side of the serial lines.
   Assumes the same frame settings as the port and a bit time of BIT clocks. */
`timescale 1ns/100ps
module spf_host_model #(
    parameter int BIT = 432
) (
    input  wire logic                 clk,
    input  wire logic                 txd_pin,
    output logic                      rxd_pin,
    input  wire logic                 eight,
    input  wire spf_pkg::spf_parity_e parity,
    output logic                      got,
    output logic [7:0]                got_byte,
    output logic                      got_bad
);
    logic paused;

    function automatic logic par_of(input logic [7:0] d);
        logic x;
        x = eight ? ^d : ^d[6:0];
        return (parity == spf_pkg::SPF_PAR_ODD) ? ~x : x;
    endfunction : par_of

    task automatic hold;
        repeat (BIT) @(posedge clk);
        #1;
    endtask : hold

    // Only the two data lines exist; no modem line is modelled.
    task automatic send(input logic [7:0] d, input logic bad);
        int i;
        // Break characters still go out while the port holds us off.
        while (paused && d != 8'h03 && d != 8'h18) begin
            @(posedge clk);
            #1;
        end
        rxd_pin = 1'b0;
        hold();
        for (i = 0; i < (eight ? 8 : 7); i++) begin
            rxd_pin = d[i];
            hold();
        end
        if (parity != spf_pkg::SPF_PAR_NONE) begin
            rxd_pin = par_of(d) ^ bad;
            hold();
        end
        rxd_pin = 1'b1;
        hold();
    endtask : send

    initial begin
        logic [7:0] d;
        logic       bad;
        int         i;
        rxd_pin = 1'b1;
        paused = 1'b0;
        got = 1'b0;
        got_byte = 8'h00;
        got_bad = 1'b0;
        forever begin
            @(negedge txd_pin);
            repeat (BIT / 2) @(posedge clk);
            d = 8'h00;
            bad = txd_pin;
            for (i = 0; i < (eight ? 8 : 7); i++) begin
                repeat (BIT) @(posedge clk);
                d[i] = txd_pin;
            end
            if (parity != spf_pkg::SPF_PAR_NONE) begin
                repeat (BIT) @(posedge clk);
                bad = bad | (txd_pin !== par_of(d));
            end
            repeat (BIT) @(posedge clk);
            bad = bad | (txd_pin !== 1'b1);
            if (d == 8'h13) paused = 1'b1;
            if (d == 8'h11) paused = 1'b0;
            got_byte <= d;
            got_bad <= bad;
            got <= 1'b1;
            @(posedge clk);
            got <= 1'b0;
        end
    end
endmodule : spf_host_model

// file: bench/spf_serial_port_tb.sv
/* Self-checking bench for spf_serial_port with a host model on the serial lines.
   Assumes the checker bind is compiled and 57600 baud, i.e. 432 clocks a bit. */
`timescale 1ns/100ps
module spf_serial_port_tb;
    localparam int BIT = 432;
    logic              clk, rst, clk_en, rxd_pin, txd_pin, out_valid, out_last, out_ready;
    logic              line_ready, line_pop, abort_pulse, rx_parity_err, rx_overrun, tx_held;
    logic              h_got, h_bad;
    logic [7:0]        out_data, line_data, h_byte, b;
    logic [7:0]        exp_q[$];
    spf_pkg::spf_cfg_s cfg;
    int                fail_count, n_tests, n_abort, k;

    spf_serial_port #(.DEPTH(4)) u_dut (.clk(clk), .rst(rst), .clk_en(clk_en), .cfg(cfg),
        .rxd_pin(rxd_pin), .txd_pin(txd_pin), .out_valid(out_valid), .out_data(out_data),
        .out_last(out_last), .out_ready(out_ready), .line_ready(line_ready),
        .line_data(line_data), .line_pop(line_pop), .abort_pulse(abort_pulse),
        .rx_parity_err(rx_parity_err), .rx_overrun(rx_overrun), .tx_held(tx_held));
    // The host always follows the port data bits and parity settings.
    spf_host_model #(.BIT(BIT)) u_host (.clk(clk), .txd_pin(txd_pin), .rxd_pin(rxd_pin),
        .eight(cfg.eight_bits), .parity(cfg.parity), .got(h_got), .got_byte(h_byte),
        .got_bad(h_bad));

    // ==========================================================================
    // Checking
    // ==========================================================================
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t byte %h expected %h", $time, g, e);
        end
    endtask : chk8

    task automatic chk1(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %0t flag %b expected %b", $time, g, e);
        end
    endtask : chk1

    always @(posedge clk) begin
        if (h_got === 1'b1) begin
            chk1(h_bad, 1'b0);
            if (exp_q.size() == 0) begin
                fail_count++;
                $display("[ERR] %0t unexpected byte %h", $time, h_byte);
            end else begin
                chk8(h_byte, exp_q.pop_front());
            end
        end
        if (abort_pulse === 1'b1) begin
            n_abort++;
        end
    end

    task automatic conclude;
        $display("checks %0d errors %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    // ==========================================================================
    // Drivers
    // ==========================================================================
    task automatic offer(input logic [7:0] d, input logic last);
        int n = 0;
        out_data = d;
        out_last = last;
        out_valid = 1'b1;
        do begin
            @(negedge clk);
            n++;
        end while (out_ready !== 1'b1 && n < 20000);
        if (n >= 20000) fail_count++;
        @(posedge clk);
        #1;
        out_valid = 1'b0;
    endtask : offer

    task automatic drain;
        for (k = 0; k < 60000 && exp_q.size() != 0; k++) @(posedge clk);
        if (k >= 60000) fail_count++;
        #1;
    endtask : drain

    function automatic logic [7:0] rnd;
        return 8'h20 + 8'($urandom % 64);
    endfunction : rnd

    // ==========================================================================
    // Tests
    // ==========================================================================
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        repeat (98000) @(posedge clk);
        fail_count++;
        conclude();
    end

    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        out_valid = 1'b0;
        out_data = 8'h00;
        out_last = 1'b0;
        line_pop = 1'b0;
        cfg = '{4'h0, 1'b1, spf_pkg::SPF_PAR_EVEN, spf_pkg::SPF_TERM_CRLF, 1'b1};
        void'($urandom(8034));
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        chk1(txd_pin, 1'b1);
        b = rnd();
        exp_q = '{b, 8'h0d, 8'h0a};
        offer(b, 1'b1);
        drain();
        b = rnd();
        u_host.send(b, 1'b0);
        chk1(line_ready, 1'b0);
        u_host.send(8'h0d, 1'b0);
        repeat (4) @(posedge clk);
        #1;
        chk1(line_ready, 1'b1);
        chk8(line_data, b);
        for (k = 0; k < 8 && line_ready === 1'b1; k++) begin
            line_pop = 1'b1;
            @(posedge clk);
            #1;
            line_pop = 1'b0;
            @(posedge clk);
            #1;
        end
        chk1(line_ready, 1'b0);
        u_host.send(8'h13, 1'b0);
        chk1(tx_held, 1'b1);
        b = rnd();
        fork
            offer(b, 1'b0);
            begin
                repeat (3000) @(posedge clk);
                #1;
                exp_q.push_back(b);
                u_host.send(8'h11, 1'b0);
            end
        join
        chk1(tx_held, 1'b0);
        drain();
        for (k = 0; k < 5; k++) begin
            if (k == 3) exp_q.push_back(8'h13);
            u_host.send(rnd(), 1'b0);
        end
        chk1(rx_overrun, 1'b1);
        exp_q.push_back(8'h11);
        u_host.send(8'h03, 1'b0);
        u_host.send(8'h18, 1'b0);
        chk8(8'(n_abort), 8'h02);
        drain();
        cfg.eight_bits = 1'b0;
        cfg.parity = spf_pkg::SPF_PAR_ODD;
        chk1(rx_parity_err, 1'b0);
        u_host.send(rnd(), 1'b1);
        chk1(rx_parity_err, 1'b1);
        cfg.parity = spf_pkg::SPF_PAR_NONE;
        cfg.term = spf_pkg::SPF_TERM_LF;
        b = rnd();
        exp_q = '{b, 8'h0a};
        offer(b, 1'b1);
        drain();
        conclude();
    end
endmodule : spf_serial_port_tb
